// ==== logic/lfrc_defines.svh ====
// Offsets, field positions, reset values and timing counts of the wake-up receiver control block.
// Summary of operation
// - Sync select bits 5:4, reset to 01.
// - Carrier mode flags carrier after time and count.
// - Data mode uses detect time before powering chain.
// - Receiver reset clears detect-time field.
// - Code 0000 needs eight carrier periods.
// - Code 1111 needs 1024 periods, both modes.
// - Long times: periodic auto-zero bridges carrier.
// - Enabled flags request interrupt, never globally masked.
// - Data-ready enable bit 7, reset clear.
// - Receive-error enable bit 6, reset clear.
// - Carrier enable bit 5, ignored in data mode with decoder on.
// - Identifier-match enable bit 4, reset clear.
// - Decoder enable bit 3; off suppresses decode flags.
// - Validation enable bit 2; off skips validation.
// - Data mode sync search stops after limit.
// - Limit codes: none, 8, 24, 48 ms.
// - Mode alternate flips mode each receiver sequence.
// - Acknowledge clears six flags, reads zero.
`ifndef LFRC_DEFINES_SVH
`define LFRC_DEFINES_SVH

// Byte addresses of the register words.
`define LFRC_CTL3_OFS       4'h0
`define LFRC_IEN_OFS        4'h4
`define LFRC_STAT_OFS       4'h8
`define LFRC_MODE_OFS       4'hc

// Field positions.
`define LFRC_DET_OUT_BIT    7
`define LFRC_ALT_BIT        6
`define LFRC_ACK_BIT        0
`define LFRC_CARRIER_MODE_SELECT_BIT     0

// Reset values.
`define LFRC_CTL3_RST       8'h10
`define LFRC_IEN_RST        8'h0c
`define LFRC_MODE_RST       8'h11

// Timing: one receiver oscillator period is 8 us.
`define LFRC_OSC_PERIOD_US  8
`define LFRC_AZ_PERIOD_US   1000
`define LFRC_AZ_LEN_US      64
`define LFRC_AZ_PERIOD_TK   (`LFRC_AZ_PERIOD_US / `LFRC_OSC_PERIOD_US)
`define LFRC_AZ_LEN_TK      (`LFRC_AZ_LEN_US / `LFRC_OSC_PERIOD_US)
`define LFRC_TO1_US         8000
`define LFRC_TO2_US         24000
`define LFRC_TO3_US         48000
`define LFRC_BASE_PERIODS   8
`define LFRC_LONG_PERIODS   128

`endif

// ==== logic/lfrc_pkg.sv ====
// Types shared by the wake-up receiver control block.
package lfrc_pkg;
  // Receiver sequence states, one-hot.
  typedef enum logic [3:0] {
    LFRC_OFF    = 4'b0001,
    LFRC_DETECT = 4'b0010,
    LFRC_SEARCH = 4'b0100,
    LFRC_DECODE = 4'b1000
  } lfrc_state_t;
  // Timer count width, big enough for the 48 ms search limit.
  typedef logic [12:0] lfrc_cnt_t;
endpackage

// ==== logic/lfrc_tmr_if.sv ====
// Control and result signals between the sequencer and a tick timer.
`timescale 1ns/10ps
interface lfrc_tmr_if;
  logic                clear;   // Restart the count at zero.
  logic                run;     // Count ticks while high.
  logic                tick;    // One oscillator tick, one cycle.
  lfrc_pkg::lfrc_cnt_t target;  // Ticks needed for done.
  logic                done;    // Count has reached target.
  modport ctl (output clear, output run, output tick, output target, input done);
  modport cnt (input clear, input run, input tick, input target, output done);
endinterface

// ==== logic/lfrc_tick_timer.sv ====
// Tick counter used for carrier detect times and the sync search limit.
`timescale 1ns/10ps
module lfrc_tick_timer (
  input  wire logic core_clk,
  input  wire logic reset_n,
  lfrc_tmr_if.cnt   tmr
);
  import lfrc_pkg::*;

  lfrc_cnt_t count_r;    // Ticks seen since the last clear.
  lfrc_cnt_t count_nxt;  // Next tick count.

  // Done is a plain compare so the sequencer sees it in the same cycle.
  assign tmr.done = (count_r >= tmr.target);

  // Clear has priority; counting stops once the target is reached.
  always_comb begin
    count_nxt = count_r;
    if (tmr.clear) begin
      count_nxt = '0;
    end else if (tmr.run && tmr.tick && !tmr.done) begin
      count_nxt = count_r + 13'h1;
    end
  end

  // Count register.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // The count never passes its target while running.
  a_tmr_bound: assert property (@(posedge core_clk) disable iff (!reset_n)
    (tmr.run && !tmr.clear && count_r < tmr.target) |=> (count_r <= $past(tmr.target)))
    else $error("Timer ran past its target.");
endmodule

// ==== logic/lfrc_core.sv ====
// Control, enables, flags and sequencer of the low-frequency wake-up receiver.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "lfrc_defines.svh"
module lfrc_core (
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  input  wire logic [3:0]    avs_address,
  input  wire logic          avs_read,
  input  wire logic          avs_write,
  input  wire logic [31:0]   avs_writedata,
  input  wire logic [3:0]    avs_byteenable,
  output logic [31:0]        avs_readdata,
  output logic               avs_waitrequest,
  input  wire logic          detector_output_bit,
  input  wire logic          receiver_osc_125k,
  input  wire logic          rx_on_req,
  input  wire logic          sync_found,
  input  wire logic          frame_end,
  input  wire logic          data_ready_evt,
  input  wire logic          rx_error_evt,
  input  wire logic          id_match_evt,
  input  wire logic          overflow_evt,
  input  wire logic          eom_evt,
  output logic [1:0]         sync_sel,
  output logic               rx_chain_on,
  output logic               decode_active,
  output lfrc_pkg::lfrc_state_t rx_state,
  output logic               irq_req
);
  import lfrc_pkg::*;

  // Carrier periods needed for a detect code in the given mode.
  function automatic lfrc_cnt_t detect_periods(input logic [3:0] code, input logic carmode);
    lfrc_cnt_t full;
    full = lfrc_cnt_t'(`LFRC_BASE_PERIODS) << code[2:0];
    if (carmode || code[3]) begin
      detect_periods = full;
    end else begin
      detect_periods = lfrc_cnt_t'(`LFRC_BASE_PERIODS);
    end
  endfunction

  // Ticks of the search limit code; zero means search forever.
  function automatic lfrc_cnt_t limit_ticks(input logic [1:0] code);
    case (code)
      2'h1:    limit_ticks = lfrc_cnt_t'(`LFRC_TO1_US / `LFRC_OSC_PERIOD_US);
      2'h2:    limit_ticks = lfrc_cnt_t'(`LFRC_TO2_US / `LFRC_OSC_PERIOD_US);
      2'h3:    limit_ticks = lfrc_cnt_t'(`LFRC_TO3_US / `LFRC_OSC_PERIOD_US);
      default: limit_ticks = '0;
    endcase
  endfunction

  // Pin synchronisers; the first stage feeds only the second.
  logic [1:0] car_sync_r;   // Detector output, two stages.
  logic [2:0] osc_sync_r;   // Oscillator, two stages plus edge history.
  logic       carrier_s;    // Synchronised carrier presence.
  logic       osc_tick;     // One cycle per oscillator rising edge.

  // Registers and their next values.
  logic [7:0]  ctl3_r,   ctl3_nxt;   // Alternate, sync select, detect time.
  logic [7:0]  ien_r,    ien_nxt;    // Interrupt enables and feature enables.
  logic [7:0]  mode_r,   mode_nxt;   // Validation count and mode select.
  logic [5:0]  flags_r,  flags_nxt;  // Ready, error, carrier, id, overflow, eom.
  logic        ack_r,    ack_nxt;    // Bus answer cycle.
  logic [31:0] rdata_r,  rdata_nxt;  // Captured read data.
  lfrc_state_t state_r,  state_nxt;  // Receiver sequence state.
  logic [3:0]  cons_r,   cons_nxt;   // Consecutive validations.
  logic        curmode_r, curmode_nxt; // Mode used by the running sequence.
  logic [6:0]  az_cnt_r, az_cnt_nxt; // Position in the auto-zero interval.

  // Combinational helpers.
  logic       wr_go;      // Write takes effect this cycle.
  logic       ack_wr;     // Acknowledge bit written.
  logic       long_time;  // Detect time long enough for auto-zero.
  logic       az_on;      // Auto-zero window active.
  logic       carr_eff;   // Carrier seen, bridged through auto-zero.
  logic       det_ok;     // Detect time met, or validation skipped.
  logic       cd_set;     // Carrier detect event.
  logic       dec_on;     // Digital decoder enabled.
  logic [7:0] stat_rd;    // Status register read view.

  lfrc_tmr_if det_if ();   // Detect-time timer.
  lfrc_tmr_if srch_if ();  // Sync search timer.

  lfrc_tick_timer u_det_tmr (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .tmr      (det_if)
  );

  lfrc_tick_timer u_srch_tmr (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .tmr      (srch_if)
  );

  assign carrier_s = car_sync_r[1];
  assign osc_tick  = osc_sync_r[1] && !osc_sync_r[2];
  assign dec_on    = ien_r[3];
  assign sync_sel  = ctl3_r[5:4];

  // Auto-zero: the detector is blind for a short window each interval, so during
  // it the carrier is taken as present for long detect times; if it is gone at the end the count restarts.
  assign long_time = detect_periods(ctl3_r[3:0], curmode_r) >= `LFRC_LONG_PERIODS;
  assign az_on     = az_cnt_r < 7'(`LFRC_AZ_LEN_TK);
  assign carr_eff  = carrier_s || (long_time && az_on);

  // Timer hookups; the detect timer restarts whenever the carrier drops.
  assign det_if.tick    = osc_tick;
  assign det_if.run     = (state_r == LFRC_DETECT) && carr_eff;
  assign det_if.target  = detect_periods(ctl3_r[3:0], curmode_r);
  assign srch_if.tick   = osc_tick;
  assign srch_if.run    = (state_r == LFRC_SEARCH);
  assign srch_if.target = limit_ticks(ien_r[1:0]);
  assign srch_if.clear  = (state_r != LFRC_SEARCH);

  // With validation off, the raw carrier is enough.
  assign det_ok = ien_r[2] ? det_if.done : carrier_s;

  // Sequencer: detect, then flag (carrier mode) or search and decode (data mode).
  always_comb begin
    state_nxt    = state_r;
    cons_nxt     = cons_r;
    curmode_nxt  = curmode_r;
    cd_set       = 1'b0;
    det_if.clear = (state_r != LFRC_DETECT) || !carr_eff;
    case (state_r)
      LFRC_OFF: begin
        cons_nxt = 4'h0;
        if (rx_on_req) begin
          state_nxt = LFRC_DETECT;
        end
      end
      LFRC_DETECT: begin
        if (!carr_eff) begin
          cons_nxt = 4'h0;
        end else if (det_ok && curmode_r) begin
          // Each validation restarts the timer until the count is reached.
          det_if.clear = 1'b1;
          cons_nxt     = cons_r + 4'h1;
          if ((cons_r + 4'h1) >= ((mode_r[7:4] == 4'h0) ? 4'h1 : mode_r[7:4])) begin
            cd_set    = 1'b1;
            state_nxt = LFRC_OFF;
          end
        end else if (det_ok) begin
          // Chain powers up; later the detect time no longer matters.
          state_nxt = LFRC_SEARCH;
          cd_set    = !dec_on;
        end
      end
      LFRC_SEARCH: begin
        if (sync_found) begin
          state_nxt = LFRC_DECODE;
        end else if (ien_r[1:0] != 2'h0 && srch_if.done) begin
          state_nxt = LFRC_OFF;
        end
      end
      LFRC_DECODE: begin
        if (frame_end) begin
          state_nxt = LFRC_OFF;
        end
      end
      default: begin
        state_nxt = LFRC_OFF;
      end
    endcase
    // Alternate mode flips the mode for the next sequence.
    if (state_r != LFRC_OFF && state_nxt == LFRC_OFF && ctl3_r[`LFRC_ALT_BIT]) begin
      curmode_nxt = !curmode_r;
    end
    if (wr_go && avs_address == `LFRC_MODE_OFS) begin
      curmode_nxt = avs_writedata[`LFRC_CARRIER_MODE_SELECT_BIT];
    end
  end

  // Auto-zero interval counter, free running on oscillator ticks.
  always_comb begin
    az_cnt_nxt = az_cnt_r;
    if (osc_tick) begin
      az_cnt_nxt = (az_cnt_r == 7'(`LFRC_AZ_PERIOD_TK - 1)) ? 7'h0 : az_cnt_r + 7'h1;
    end
  end

  // Avalon slave: waitrequest for one cycle, then the answer; writes land at the answer edge.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_go           = avs_write && ack_r && avs_byteenable[0];
  assign ack_wr          = wr_go && avs_address == `LFRC_STAT_OFS &&
                           avs_writedata[`LFRC_ACK_BIT];
  assign stat_rd         = {flags_r, 2'b00};  // Acknowledge always reads zero.
  assign avs_readdata    = rdata_r;

  // Register writes and read capture.
  always_comb begin
    ack_nxt   = (avs_read || avs_write) && !ack_r;
    rdata_nxt = rdata_r;
    ctl3_nxt  = ctl3_r;
    ien_nxt   = ien_r;
    mode_nxt  = mode_r;
    if (avs_read && !ack_r) begin
      case (avs_address)
        `LFRC_CTL3_OFS: rdata_nxt = {24'h0, carrier_s, ctl3_r[6:0]};
        `LFRC_IEN_OFS:  rdata_nxt = {24'h0, ien_r};
        `LFRC_STAT_OFS: rdata_nxt = {24'h0, stat_rd};
        `LFRC_MODE_OFS: rdata_nxt = {24'h0, mode_r[7:1], curmode_r};
        default:        rdata_nxt = 32'h0;
      endcase
    end
    if (wr_go) begin
      case (avs_address)
        `LFRC_CTL3_OFS: ctl3_nxt = {1'b0, avs_writedata[6:0]};
        `LFRC_IEN_OFS:  ien_nxt  = avs_writedata[7:0];
        `LFRC_MODE_OFS: mode_nxt = {avs_writedata[7:4], 3'h0, avs_writedata[0]};
        default:        ien_nxt  = ien_r;
      endcase
    end
  end

  // Flags: acknowledge clears all six, but a same-cycle event still sets.
  // With the decoder off, no decode flag can rise.
  always_comb begin
    flags_nxt = ack_wr ? 6'h00 : flags_r;
    flags_nxt = flags_nxt | {data_ready_evt & dec_on,
                             rx_error_evt & dec_on & !curmode_r,
                             cd_set,
                             id_match_evt & dec_on,
                             overflow_evt & dec_on,
                             eom_evt & dec_on};
  end

  // One request line; the carrier term is gated off in data mode with the decoder on.
  // Software should clear flags before enabling, else this fires at once.
  assign irq_req = (flags_r[5] & ien_r[7]) | (flags_r[4] & ien_r[6]) |
                   (flags_r[3] & ien_r[5] & (curmode_r | !dec_on)) |
                   (flags_r[2] & ien_r[4]);

  assign rx_chain_on   = (state_r == LFRC_SEARCH) || (state_r == LFRC_DECODE);
  assign decode_active = (state_r == LFRC_DECODE);
  assign rx_state      = state_r;

  // All state registers; reset loads the documented defaults.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      car_sync_r <= 2'h0;
      osc_sync_r <= 3'h0;
      ctl3_r     <= `LFRC_CTL3_RST;
      ien_r      <= `LFRC_IEN_RST;
      mode_r     <= `LFRC_MODE_RST;
      flags_r    <= 6'h00;
      ack_r      <= 1'b0;
      rdata_r    <= 32'h0;
      state_r    <= LFRC_OFF;
      cons_r     <= 4'h0;
      curmode_r  <= 1'b1;
      az_cnt_r   <= 7'h0;
    end else begin
      car_sync_r <= {car_sync_r[0], detector_output_bit};
      osc_sync_r <= {osc_sync_r[1:0], receiver_osc_125k};
      ctl3_r     <= ctl3_nxt;
      ien_r      <= ien_nxt;
      mode_r     <= mode_nxt;
      flags_r    <= flags_nxt;
      ack_r      <= ack_nxt;
      rdata_r    <= rdata_nxt;
      state_r    <= state_nxt;
      cons_r     <= cons_nxt;
      curmode_r  <= curmode_nxt;
      az_cnt_r   <= az_cnt_nxt;
    end
  end

  // Acknowledge write with no new events leaves every flag clear.
  sequence s_ack_quiet;
    ack_wr && !data_ready_evt && !rx_error_evt && !id_match_evt && !overflow_evt
      && !eom_evt && !cd_set;
  endsequence

  a_sync_rst_val: assert property (@(posedge core_clk) disable iff (!reset_n)
    !$past(reset_n) |-> (sync_sel == 2'h1 && ctl3_r[3:0] == 4'h0))
    else $error("Sync select or detect time wrong after reset.");
  a_ack_clears: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_ack_quiet |=> flags_r == 6'h00)
    else $error("Acknowledge did not clear the flags.");
  a_ack_reads_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    (avs_read && !avs_waitrequest && avs_address == `LFRC_STAT_OFS) |-> !avs_readdata[0])
    else $error("Acknowledge bit read as one.");
  a_drdy_irq: assert property (@(posedge core_clk) disable iff (!reset_n)
    (flags_r[5] && ien_r[7]) |-> irq_req)
    else $error("Data ready did not request an interrupt.");
  a_cd_gated: assert property (@(posedge core_clk) disable iff (!reset_n)
    (flags_r == 6'h08 && !curmode_r && dec_on) |-> !irq_req)
    else $error("Carrier term not gated in decoding data mode.");
  a_decoff_flags: assert property (@(posedge core_clk) disable iff (!reset_n)
    !dec_on && !ack_wr && !$rose(ien_r[3]) |=> flags_r[5] == $past(flags_r[5]))
    else $error("Data flag rose with decoder off.");
  a_cd_carrier: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(flags_r[3]) |-> $past(carr_eff) && $past(state_r == LFRC_DETECT))
    else $error("Carrier flag without a detected carrier.");
  a_no_timeout: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_r == LFRC_SEARCH && ien_r[1:0] == 2'h0 && !sync_found) |=> state_r == LFRC_SEARCH)
    else $error("Search ended with no limit selected.");
  a_chain_after: assert property (@(posedge core_clk) disable iff (!reset_n)
    $rose(rx_chain_on) |-> $past(det_ok) && !$past(curmode_r))
    else $error("Receive chain powered before detect time.");
  a_alt_flip: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_r != LFRC_OFF && state_nxt == LFRC_OFF && ctl3_r[6] && !wr_go)
      |=> curmode_r != $past(curmode_r))
    else $error("Mode did not alternate at sequence end.");
endmodule

// ==== testbench/lfrc_lf_front.sv ====
// Model of the analog carrier detector and the receiver oscillator.
`timescale 1ns/10ps
module lfrc_lf_front #(
  parameter int HALF_NS = 210  // Half period; fast so that long tick counts stay short.
) (
  input  wire logic carrier_on,
  output logic      detector_output_bit,
  output logic      receiver_osc_125k
);
  // The oscillator runs free; its period is no multiple of the core clock.
  initial begin
    receiver_osc_125k = 1'b0;
    forever #(HALF_NS) receiver_osc_125k = ~receiver_osc_125k;
  end
  // The slicer output is high only while a carrier is above threshold.
  assign detector_output_bit = carrier_on;
endmodule

// ==== testbench/lf_wakeup_receiver_control_tb_top.sv ====
// Self-checking bench for the wake-up receiver control block.
`timescale 1ns/10ps
`include "lfrc_defines.svh"
module lf_wakeup_receiver_control_tb_top;
  import lfrc_pkg::*;
  logic        core_clk;        // Core clock, 50 ns.
  logic        reset_n;         // Asynchronous reset, active low.
  logic [3:0]  avs_address;     // Bus address.
  logic [3:0]  avs_byteenable;  // Bus byte lanes.
  logic        avs_read;        // Read request.
  logic        avs_write;       // Write request.
  logic        avs_waitrequest; // Slave stall.
  logic [31:0] avs_writedata;   // Write data.
  logic [31:0] avs_readdata;    // Read data.
  logic        carrier_on;      // Carrier present at the antenna.
  logic        det_bit;         // Detector output from the model.
  logic        osc;             // Receiver oscillator from the model.
  logic [7:0]  ev;              // Pulses: rdy, err, id, ovf, eom, on, sync, end.
  logic [1:0]  sync_sel;        // Sync pattern selection.
  logic        rx_chain_on;     // Receive chain powered.
  logic        decode_active;   // Decoding in progress.
  logic        irq_req;         // Interrupt request.
  lfrc_state_t rx_state;        // Sequencer state.
  logic [31:0] seed;            // Random state.
  logic [31:0] rd;              // Last read data.
  int          n_fail;          // Mismatches seen.
  int          total_checks;    // Comparisons made.
  int          n;               // Cycles counted by a wait.
  int          bp;              // Status bit position.

  lfrc_lf_front lfrc_lf_front_inst (
    .carrier_on          (carrier_on),
    .detector_output_bit (det_bit),
    .receiver_osc_125k   (osc)
  );

  lfrc_core lfrc_core_inst (
    .core_clk            (core_clk),
    .reset_n             (reset_n),
    .avs_address         (avs_address),
    .avs_read            (avs_read),
    .avs_write           (avs_write),
    .avs_writedata       (avs_writedata),
    .avs_byteenable      (avs_byteenable),
    .avs_readdata        (avs_readdata),
    .avs_waitrequest     (avs_waitrequest),
    .detector_output_bit (det_bit),
    .receiver_osc_125k   (osc),
    .rx_on_req           (ev[5]),
    .sync_found          (ev[6]),
    .frame_end           (ev[7]),
    .data_ready_evt      (ev[0]),
    .rx_error_evt        (ev[1]),
    .id_match_evt        (ev[2]),
    .overflow_evt        (ev[3]),
    .eom_evt             (ev[4]),
    .sync_sel            (sync_sel),
    .rx_chain_on         (rx_chain_on),
    .decode_active       (decode_active),
    .rx_state            (rx_state),
    .irq_req             (irq_req)
  );

  // Free-running core clock.
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // Xorshift step for repeatable random register values.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Carrier periods needed for a detect-time code; data mode uses 8 unless bit 3 is set.
  function automatic int periods(input logic [3:0] c, input logic car);
    return (car || c[3]) ? (8 << c[2:0]) : 8;
  endfunction

  // Oscillator ticks of a sync search limit code: nominal milliseconds at 125 ticks each.
  function automatic int lim_ticks(input logic [1:0] c);
    return (c == 2'b01) ? 8 * 125 : (c == 2'b10) ? 24 * 125 : 48 * 125;
  endfunction

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (n_fail == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A wait that runs out of cycles ends the run as a failure.
  task automatic lost();
    n_fail++;
    $display("ERROR %0t: wait limit reached", $time);
    summarize();
  endtask

  // One bus access; the request is held until waitrequest is sampled low at a rising edge.
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    int k;
    @(posedge core_clk);
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_write     <= wr;
    avs_read      <= ~wr;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (k >= 20) begin
      lost();
    end
  endtask

  // Reads a register and compares it.
  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask

  // Compares the interrupt line once it has settled.
  task automatic chk_irq(input logic exp);
    @(negedge core_clk);
    chk({31'h0, irq_req}, {31'h0, exp});
  endtask

  // One-cycle pulse on an event input.
  task automatic pulse(input int i);
    @(posedge core_clk);
    ev[i] <= 1'b1;
    @(posedge core_clk);
    ev[i] <= 1'b0;
  endtask

  // Bounded wait: 0 irq high, 1 searching, otherwise back in off.
  task automatic wait_for(input int sel, input int lim, output int cyc);
    cyc = 0;
    while (!(sel == 0 ? irq_req === 1'b1 : sel == 1 ? rx_state === LFRC_SEARCH
           : rx_state === LFRC_OFF) && cyc < lim) begin
      @(negedge core_clk);
      cyc++;
    end
    if (cyc >= lim) begin
      lost();
    end
  endtask

  // Main sequence.
  initial begin
    avs_address = 4'h0;
    avs_byteenable = 4'hf;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    ev = 8'h00;
    carrier_on = 1'b0;
    reset_n = 1'b0;
    seed = 32'd13;
    n_fail = 0;
    total_checks = 0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    chk({28'h0, rx_state}, {28'h0, LFRC_OFF});
    rdchk(`LFRC_CTL3_OFS, 32'h10);
    chk({30'h0, sync_sel}, 32'h1);
    rdchk(`LFRC_IEN_OFS, 32'h0c);
    rdchk(`LFRC_STAT_OFS, 32'h0);
    rdchk(4'h2, 32'h0);
    // Random control values read back; the detector level bit stays read-only.
    repeat (4) begin
      seed = xs(seed);
      bus(1'b1, `LFRC_CTL3_OFS, seed[7:0]);
      rdchk(`LFRC_CTL3_OFS, {25'h0, seed[6:0]});
      chk({30'h0, sync_sel}, {30'h0, seed[5:4]});
      bus(1'b1, `LFRC_IEN_OFS, seed[15:8]);
      rdchk(`LFRC_IEN_OFS, {24'h0, seed[15:8]});
    end
    // A write with no byte lane enabled must not land.
    avs_byteenable <= 4'h0;
    bus(1'b1, `LFRC_IEN_OFS, ~seed[15:8]);
    avs_byteenable <= 4'hf;
    rdchk(`LFRC_IEN_OFS, {24'h0, seed[15:8]});
    // Each decode flag raised and acknowledged; ready, error and id also first with their enable off, then on.
    bus(1'b1, `LFRC_CTL3_OFS, 8'h10);
    bus(1'b1, `LFRC_MODE_OFS, 8'h10);
    bus(1'b1, `LFRC_IEN_OFS, 8'h0c);
    bus(1'b1, `LFRC_STAT_OFS, 8'h01);
    for (int i = 0; i < 5; i++) begin
      bp = (i < 2) ? 7 - i : 6 - i;
      pulse(i);
      rdchk(`LFRC_STAT_OFS, 32'h1 << bp);
      chk_irq(1'b0);
      bus(1'b1, `LFRC_IEN_OFS, 8'h0c | (8'h01 << bp));
      chk_irq(i < 3);
      bus(1'b1, `LFRC_STAT_OFS, 8'h01);
      rdchk(`LFRC_STAT_OFS, 32'h0);
      chk_irq(1'b0);
      bus(1'b1, `LFRC_IEN_OFS, 8'h0c);
    end
    // Carrier mode: shortest code with two validations, longest code with one.
    bus(1'b1, `LFRC_IEN_OFS, 8'h2c);
    carrier_on <= 1'b1;
    for (int c = 0; c < 16; c += 15) begin
      bus(1'b1, `LFRC_MODE_OFS, (c == 0) ? 8'h21 : 8'h11);
      bus(1'b1, `LFRC_CTL3_OFS, c[7:0]);
      pulse(5);
      wait_for(0, 12000, n);
      bp = periods(c[3:0], 1'b1) * ((c == 0) ? 16 : 8);
      chk({31'h0, n >= bp - 4 && n <= bp + bp / 8 + 24}, 32'h1);
      rdchk(`LFRC_STAT_OFS, 32'h20);
      bus(1'b1, `LFRC_STAT_OFS, 8'h01);
    end
    // Validation and decoding off, mode alternation on.
    bus(1'b1, `LFRC_CTL3_OFS, 8'h4f);
    rdchk(`LFRC_CTL3_OFS, 32'hcf);
    bus(1'b1, `LFRC_IEN_OFS, 8'h20);
    pulse(5);
    wait_for(0, 100, n);
    wait_for(2, 20, n);
    rdchk(`LFRC_MODE_OFS, 32'h10);
    bus(1'b1, `LFRC_STAT_OFS, 8'h01);
    bus(1'b1, `LFRC_CTL3_OFS, 8'h10);
    // Data mode: short detect, then the 8 ms and the 24 ms search limits run out.
    for (int t = 1; t < 3; t++) begin
      bus(1'b1, `LFRC_IEN_OFS, 8'h2c | t[7:0]);
      pulse(5);
      wait_for(1, 8 * periods(4'h0, 1'b0) + 40, n);
      chk({31'h0, rx_chain_on}, 32'h1);
      chk_irq(1'b0);
      wait_for(2, 28000, n);
      bp = lim_ticks(t[1:0]) * 8;
      chk({31'h0, n >= bp - 4 && n <= bp + bp / 8 + 24}, 32'h1);
    end
    // No limit: the search holds until sync, then decoding runs to frame end.
    bus(1'b1, `LFRC_STAT_OFS, 8'h01);
    bus(1'b1, `LFRC_IEN_OFS, 8'h0c);
    pulse(5);
    wait_for(1, 200, n);
    repeat (3000) @(posedge core_clk);
    chk({28'h0, rx_state}, {28'h0, LFRC_SEARCH});
    pulse(6);
    @(negedge core_clk);
    chk({27'h0, decode_active, rx_state}, {27'h1, LFRC_DECODE});
    pulse(7);
    wait_for(2, 10, n);
    // Decoder off in data mode: no decode flags, carrier interrupt honoured.
    bus(1'b1, `LFRC_IEN_OFS, 8'h24);
    bus(1'b1, `LFRC_STAT_OFS, 8'h01);
    pulse(0);
    rdchk(`LFRC_STAT_OFS, 32'h0);
    pulse(5);
    wait_for(0, 200, n);
    rdchk(`LFRC_STAT_OFS, 32'h20);
    // Decoder back on in data mode: the pending carrier flag must stop interrupting.
    bus(1'b1, `LFRC_IEN_OFS, 8'h2c);
    chk_irq(1'b0);
    summarize();
  end
endmodule
